// [hdl/dac_data_decode.sv]
// decode of serial write frames into per-channel data registers
// How it works
// - frame is 24 bits: rw, chip address, select, channel, 16-bit payload
// - frame acted upon only if chip address equals the two strap inputs
// - select 010 loads payload into gain of addressed channel
// - select 011 loads payload into gain of all four channels
// - select 100 loads payload into offset of addressed channel
// - select 101 loads payload into offset of all four channels
// - select 110 stores payload as clear value of addressed channel
// - select 111 hands frame to control-register path with its sub-field
// - channel field picks A..D by 00..11, ignored where irrelevant
// - data write takes output code from payload bits 15..0
// - gain register is 16-bit straight binary
// - gain resets to all ones
// - offset register is 16-bit straight binary around mid-scale
// - offset resets to mid-scale 8000
// - clear value resets to zero
// - per-channel enable chooses whether clear input loads clear value
`timescale 1ns/10ps
`default_nettype none
module dac_data_decode (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    // address straps from pins
    input wire logic CHIP_STRAP_HIGH_I,
    input wire logic CHIP_STRAP_LOW_I,
    // frame from serial shifter
    input wire logic FRAME_VALID_I,
    input wire logic [23:0] FRAME_I,
    // clear input from pin and per-channel enables
    input wire logic CLEAR_I,
    input wire logic [3:0] CLEAR_ENABLE_I,
    // register contents
    output logic [63:0] OUTPUT_CODE_O,
    output logic [63:0] GAIN_TRIM_O,
    output logic [63:0] OFFSET_TRIM_O,
    output logic [63:0] CLEAR_VALUE_O,
    // control-register hand-off
    output logic CTRL_VALID_O,
    output logic [1:0] CTRL_CHANNEL_O,
    output logic [15:0] CTRL_DATA_O
);
    // ****************************************
    // helper functions
    // ****************************************
    // true once the two oldest stages of a synchroniser hold one level
    function automatic logic agree(input logic [2:0] stages);
        agree = (stages[1] == stages[2]);
    endfunction : agree

    // one-hot channel pick, or all four for a broadcast
    function automatic logic [3:0] pick(input logic [1:0] ch, input logic all);
        logic [3:0] onehot;
        onehot = 4'h1 << ch;
        pick = all ? 4'hF : onehot;
    endfunction : pick

    // ****************************************
    // operation decode
    // ****************************************
    typedef enum logic [2:0] {
        op_none = 3'b000,
        op_code = 3'b001,
        op_gain_one = 3'b010,
        op_gain_all = 3'b011,
        op_offset_one = 3'b100,
        op_offset_all = 3'b101,
        op_clear = 3'b110,
        op_control = 3'b111
    } op_t;

    // select 001 has no register behind it and falls to op_none
    function automatic op_t decode_op(input logic [2:0] sel);
        case (sel)
            dac_decode_pkg::SEL_DATA: begin
                decode_op = op_code;
            end
            dac_decode_pkg::SEL_GAIN: begin
                decode_op = op_gain_one;
            end
            dac_decode_pkg::SEL_GAIN_ALL: begin
                decode_op = op_gain_all;
            end
            dac_decode_pkg::SEL_OFFSET: begin
                decode_op = op_offset_one;
            end
            dac_decode_pkg::SEL_OFFSET_ALL: begin
                decode_op = op_offset_all;
            end
            dac_decode_pkg::SEL_CLEAR: begin
                decode_op = op_clear;
            end
            dac_decode_pkg::SEL_CONTROL: begin
                decode_op = op_control;
            end
            default: begin
                decode_op = op_none;
            end
        endcase
    endfunction : decode_op

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] strap_hi_sync;
    logic [2:0] strap_lo_sync;
    logic [2:0] clear_sync;
    logic strap_hi;
    logic strap_lo;
    logic clear_level;

    // straps are static in use but still cross in from pins
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            strap_hi_sync <= 3'h0;
        end else begin
            strap_hi_sync <= {strap_hi_sync[1:0], CHIP_STRAP_HIGH_I};
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            strap_lo_sync <= 3'h0;
        end else begin
            strap_lo_sync <= {strap_lo_sync[1:0], CHIP_STRAP_LOW_I};
        end
    end

    // clear is asynchronous to the clock; about four cycles of latency
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            clear_sync <= 3'h0;
        end else begin
            clear_sync <= {clear_sync[1:0], CLEAR_I};
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            strap_hi <= 1'b0;
        end else if (agree(strap_hi_sync)) begin
            strap_hi <= strap_hi_sync[2];
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            strap_lo <= 1'b0;
        end else if (agree(strap_lo_sync)) begin
            strap_lo <= strap_lo_sync[2];
        end
    end

    // a glitch on the clear pin shorter than two cycles is filtered out
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            clear_level <= 1'b0;
        end else if (agree(clear_sync)) begin
            clear_level <= clear_sync[2];
        end
    end

    // ****************************************
    // frame fields
    // ****************************************
    logic is_write;
    logic [1:0] chip_addr;
    logic [2:0] register_select_field;
    logic [1:0] channel_addr;
    logic [15:0] payload;
    logic addr_match;
    logic act;
    op_t op;

    // bit 23 low marks a write; read frames belong to the readback logic
    assign is_write = ~FRAME_I[dac_decode_pkg::RW_POS];
    assign chip_addr = FRAME_I[dac_decode_pkg::CHIP_HI:dac_decode_pkg::CHIP_LO];
    assign register_select_field = FRAME_I[dac_decode_pkg::SEL_HI:dac_decode_pkg::SEL_LO];
    assign channel_addr = FRAME_I[dac_decode_pkg::CH_HI:dac_decode_pkg::CH_LO];
    assign payload = FRAME_I[dac_decode_pkg::DATA_HI:0];
    // compared against the filtered straps, never the raw pins
    assign addr_match = (chip_addr == {strap_hi, strap_lo});
    // straps settle a few cycles after reset; frames before that may be dropped
    assign act = FRAME_VALID_I && is_write && addr_match;
    assign op = decode_op(register_select_field);

    // ****************************************
    // write enables
    // ****************************************
    logic [3:0] code_we;
    logic [3:0] gain_we;
    logic [3:0] offset_we;
    logic [3:0] clear_we;
    logic ctrl_we;

    // one-hot per channel; broadcasts light all four in the same cycle
    always_comb begin
        code_we = 4'h0;
        gain_we = 4'h0;
        offset_we = 4'h0;
        clear_we = 4'h0;
        ctrl_we = 1'b0;
        if (act) begin
            case (op)
                op_code: begin
                    code_we = pick(channel_addr, 1'b0);
                end
                op_gain_one: begin
                    gain_we = pick(channel_addr, 1'b0);
                end
                op_gain_all: begin
                    gain_we = pick(channel_addr, 1'b1);
                end
                op_offset_one: begin
                    offset_we = pick(channel_addr, 1'b0);
                end
                op_offset_all: begin
                    offset_we = pick(channel_addr, 1'b1);
                end
                op_clear: begin
                    clear_we = pick(channel_addr, 1'b0);
                end
                op_control: begin
                    ctrl_we = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // clear participation
    // ****************************************
    // level clear: enabled channels hold their clear value while it is high
    // the enables come from logic on this clock, so they need no synchroniser
    logic [3:0] clear_load;

    assign clear_load = clear_level ? CLEAR_ENABLE_I : 4'h0;

    // ****************************************
    // channel registers
    // ****************************************
    logic [15:0] code_q [4];
    logic [15:0] gain_q [4];
    logic [15:0] offset_q [4];
    logic [15:0] clear_q [4];

    // clear wins over a data write landing in the same cycle
    always_ff @(posedge MCLK_I) begin
        for (int i = 0; i < dac_decode_pkg::NUM_CH; i++) begin
            if (!RSTN_I) begin
                code_q[i] <= dac_decode_pkg::CODE_RESET;
            end else if (clear_load[i]) begin
                code_q[i] <= clear_q[i];
            end else if (code_we[i]) begin
                code_q[i] <= payload;
            end
        end
    end

    // gain trims are straight binary, all ones out of reset
    always_ff @(posedge MCLK_I) begin
        for (int i = 0; i < dac_decode_pkg::NUM_CH; i++) begin
            if (!RSTN_I) begin
                gain_q[i] <= dac_decode_pkg::GAIN_RESET;
            end else if (gain_we[i]) begin
                gain_q[i] <= payload;
            end
        end
    end

    // mid-scale offset means no adjustment
    always_ff @(posedge MCLK_I) begin
        for (int i = 0; i < dac_decode_pkg::NUM_CH; i++) begin
            if (!RSTN_I) begin
                offset_q[i] <= dac_decode_pkg::OFFSET_RESET;
            end else if (offset_we[i]) begin
                offset_q[i] <= payload;
            end
        end
    end

    // clear values only take effect through the clear pin
    always_ff @(posedge MCLK_I) begin
        for (int i = 0; i < dac_decode_pkg::NUM_CH; i++) begin
            if (!RSTN_I) begin
                clear_q[i] <= dac_decode_pkg::CLEAR_RESET;
            end else if (clear_we[i]) begin
                clear_q[i] <= payload;
            end
        end
    end

    // ****************************************
    // control path hand-off
    // ****************************************
    // one-cycle strobe so the control decode never acts twice on one frame
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            CTRL_VALID_O <= 1'b0;
        end else begin
            CTRL_VALID_O <= ctrl_we;
        end
    end

    // channel and payload stand until the next control frame
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            CTRL_CHANNEL_O <= 2'h0;
            CTRL_DATA_O <= 16'h0000;
        end else if (ctrl_we) begin
            CTRL_CHANNEL_O <= channel_addr;
            CTRL_DATA_O <= payload;
        end
    end

    // ****************************************
    // register outputs
    // ****************************************
    // flattening only: every bit is wired straight from its channel register
    always_comb begin
        for (int i = 0; i < dac_decode_pkg::NUM_CH; i++) begin
            OUTPUT_CODE_O[i*16 +: 16] = code_q[i];
        end
    end

    always_comb begin
        for (int i = 0; i < dac_decode_pkg::NUM_CH; i++) begin
            GAIN_TRIM_O[i*16 +: 16] = gain_q[i];
        end
    end

    always_comb begin
        for (int i = 0; i < dac_decode_pkg::NUM_CH; i++) begin
            OFFSET_TRIM_O[i*16 +: 16] = offset_q[i];
        end
    end

    always_comb begin
        for (int i = 0; i < dac_decode_pkg::NUM_CH; i++) begin
            CLEAR_VALUE_O[i*16 +: 16] = clear_q[i];
        end
    end
endmodule : dac_data_decode
`default_nettype wire

// [hdl/dac_decode_pkg.sv]
// constants for the four-channel data register decode
package dac_decode_pkg;
    // ****************************************
    // frame layout
    // ****************************************
    localparam int FRAME_W = 24;
    localparam int RW_POS = 23;
    localparam int CHIP_HI = 22;
    localparam int CHIP_LO = 21;
    localparam int SEL_HI = 20;
    localparam int SEL_LO = 18;
    localparam int CH_HI = 17;
    localparam int CH_LO = 16;
    localparam int DATA_HI = 15;
    localparam int NUM_CH = 4;
    // ****************************************
    // register select codes
    // ****************************************
    localparam logic [2:0] SEL_DATA = 3'h0;
    localparam logic [2:0] SEL_GAIN = 3'h2;
    localparam logic [2:0] SEL_GAIN_ALL = 3'h3;
    localparam logic [2:0] SEL_OFFSET = 3'h4;
    localparam logic [2:0] SEL_OFFSET_ALL = 3'h5;
    localparam logic [2:0] SEL_CLEAR = 3'h6;
    localparam logic [2:0] SEL_CONTROL = 3'h7;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET = 16'hFFFF;
    localparam logic [15:0] OFFSET_RESET = 16'h8000;
    localparam logic [15:0] CLEAR_RESET = 16'h0000;
    localparam logic [3:0] CLEAR_EN_RESET = 4'h0;
endpackage : dac_decode_pkg

// [testbench/dac_decode_asserts.sv]
// checker for the data register decode
`timescale 1ns/10ps
`default_nettype none
module dac_decode_asserts (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic CHIP_STRAP_HIGH_I,
    input wire logic CHIP_STRAP_LOW_I,
    input wire logic FRAME_VALID_I,
    input wire logic [23:0] FRAME_I,
    input wire logic CLEAR_I,
    input wire logic [3:0] CLEAR_ENABLE_I,
    input wire logic [63:0] OUTPUT_CODE_O,
    input wire logic [63:0] GAIN_TRIM_O,
    input wire logic [63:0] OFFSET_TRIM_O,
    input wire logic [63:0] CLEAR_VALUE_O,
    input wire logic CTRL_VALID_O,
    input wire logic [1:0] CTRL_CHANNEL_O,
    input wire logic [15:0] CTRL_DATA_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    logic hit;
    logic [2:0] sel;
    logic [15:0] pay;
    logic [5:0] at;
    assign hit = FRAME_VALID_I && !FRAME_I[23] && FRAME_I[22:21] == {CHIP_STRAP_HIGH_I, CHIP_STRAP_LOW_I};
    assign sel = FRAME_I[20:18];
    assign pay = FRAME_I[15:0];
    assign at = {FRAME_I[17:16], 4'h0};
    chk_gain_one: assert property (
        hit && sel == 3'h2 |=> 16'(GAIN_TRIM_O >> $past(at)) == $past(pay)) else $error("gain one");
    chk_gain_all: assert property (
        hit && sel == 3'h3 |=> GAIN_TRIM_O == {4{$past(pay)}}) else $error("gain all");
    chk_offs_one: assert property (
        hit && sel == 3'h4 |=> 16'(OFFSET_TRIM_O >> $past(at)) == $past(pay)) else $error("offs one");
    chk_offs_all: assert property (
        hit && sel == 3'h5 |=> OFFSET_TRIM_O == {4{$past(pay)}}) else $error("offs all");
    chk_clear_value: assert property (
        hit && sel == 3'h6 |=> 16'(CLEAR_VALUE_O >> $past(at)) == $past(pay)) else $error("clr val");
    chk_data_write: assert property (
        (!CLEAR_I)[*6] ##0 (hit && sel == 3'h0) |=> 16'(OUTPUT_CODE_O >> $past(at)) == $past(pay))
        else $error("data write");
    chk_ctrl_handoff: assert property (
        hit && sel == 3'h7 |=> CTRL_VALID_O && CTRL_DATA_O == $past(pay)
        && CTRL_CHANNEL_O == $past(FRAME_I[17:16])) else $error("ctrl handoff");
    chk_ctrl_cause: assert property (
        CTRL_VALID_O |-> $past(hit && sel == 3'h7)) else $error("ctrl pulse");
    chk_miss_hold: assert property (
        FRAME_VALID_I && !hit |=> $stable(GAIN_TRIM_O) && $stable(OFFSET_TRIM_O)
        && $stable(CLEAR_VALUE_O)) else $error("miss changed");
    chk_reset_vals: assert property (
        $rose(RSTN_I) |-> GAIN_TRIM_O == {4{16'hFFFF}} && OFFSET_TRIM_O == {4{16'h8000}}
        && CLEAR_VALUE_O == 64'h0) else $error("reset vals");
    chk_clear_load: assert property (
        (CLEAR_I && CLEAR_ENABLE_I[0])[*8] |-> OUTPUT_CODE_O[15:0] == CLEAR_VALUE_O[15:0])
        else $error("clear load");
    cov_gain_all: cover property (hit && sel == 3'h3);
    cov_ctrl: cover property (CTRL_VALID_O);
    cov_clear: cover property (CLEAR_I[*8]);
endmodule : dac_decode_asserts
bind dac_data_decode dac_decode_asserts chk_u (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
    .CHIP_STRAP_HIGH_I(CHIP_STRAP_HIGH_I), .CHIP_STRAP_LOW_I(CHIP_STRAP_LOW_I),
    .FRAME_VALID_I(FRAME_VALID_I), .FRAME_I(FRAME_I), .CLEAR_I(CLEAR_I),
    .CLEAR_ENABLE_I(CLEAR_ENABLE_I), .OUTPUT_CODE_O(OUTPUT_CODE_O), .GAIN_TRIM_O(GAIN_TRIM_O),
    .OFFSET_TRIM_O(OFFSET_TRIM_O), .CLEAR_VALUE_O(CLEAR_VALUE_O), .CTRL_VALID_O(CTRL_VALID_O),
    .CTRL_CHANNEL_O(CTRL_CHANNEL_O), .CTRL_DATA_O(CTRL_DATA_O));
`default_nettype wire

// [testbench/frame_host_model.sv]
// host side model that hands over one frame per request
`timescale 1ns/10ps
`default_nettype none
module frame_host_model (
    input wire logic clk_i,
    input wire logic send_i,
    input wire logic [23:0] word_i,
    output logic valid_o = 1'b0,
    output logic [23:0] frame_o = 24'h0
);
    // idle bus inverts every bit of the frame each cycle, so stale data cannot pass
    always_ff @(posedge clk_i) begin
        valid_o <= send_i;
        frame_o <= send_i ? word_i : ~frame_o;
    end
endmodule : frame_host_model
`default_nettype wire

// [testbench/test_quad_dac_data_register_decode.sv]
// self-checking bench for the data register decode
`timescale 1ns/10ps
`default_nettype none
module test_quad_dac_data_register_decode;
    typedef struct {int due; logic [63:0] d, g, o, c; logic cv; logic [17:0] ct;} note_t;
    logic mclk = 1'b0, rstn = 1'b0, clr = 1'b0, go = 1'b0, fv, ctv;
    logic [3:0] cen = 4'h0;
    logic [23:0] word = 24'h0, fr;
    logic [63:0] cd, gt, ot, cvl;
    logic [1:0] cch, strap = 2'h2;
    logic [15:0] cdt;
    note_t q[$];
    note_t m, w;
    int cyc = 0, n_mismatch = 0, checks_done = 0;
    always #20 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    frame_host_model host_u (.clk_i(mclk), .send_i(go), .word_i(word), .valid_o(fv), .frame_o(fr));
    dac_data_decode dut_u (.MCLK_I(mclk), .RSTN_I(rstn), .CHIP_STRAP_HIGH_I(strap[1]),
        .CHIP_STRAP_LOW_I(strap[0]), .FRAME_VALID_I(fv), .FRAME_I(fr), .CLEAR_I(clr),
        .CLEAR_ENABLE_I(cen), .OUTPUT_CODE_O(cd), .GAIN_TRIM_O(gt), .OFFSET_TRIM_O(ot),
        .CLEAR_VALUE_O(cvl), .CTRL_VALID_O(ctv), .CTRL_CHANNEL_O(cch), .CTRL_DATA_O(cdt));
    task cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task note(input int lag);
        m.due = cyc + lag;
        q.push_back(m);
        m.cv = 1'b0;
    endtask : note
    task send(input logic [2:0] sel, input logic [1:0] adr, input logic rd);
        logic [1:0] ch;
        logic [15:0] v;
        ch = 2'($urandom);
        v = 16'($urandom);
        @(posedge mclk);
        word <= {rd, adr, sel, ch, v};
        go <= 1'b1;
        if (!rd && adr == strap) begin
            case (sel)
                3'h0: m.d[16*ch+:16] = v;
                3'h2: m.g[16*ch+:16] = v;
                3'h3: m.g = {4{v}};
                3'h4: m.o[16*ch+:16] = v;
                3'h5: m.o = {4{v}};
                3'h6: m.c[16*ch+:16] = v;
                3'h7: m.ct = {ch, v};
                default: ;
            endcase
            m.cv = (sel == 3'h7);
        end
        note(3);
    endtask : send
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    always @(negedge mclk) begin
        if (q.size() > 0 && q[0].due <= cyc) begin
            w = q.pop_front();
            cmp("code", w.d, cd);
            cmp("gain", w.g, gt);
            cmp("offset", w.o, ot);
            cmp("clear value", w.c, cvl);
            cmp("ctrl valid", 64'(w.cv), 64'(ctv));
            if (w.cv) cmp("ctrl word", 64'(w.ct), 64'({cch, cdt}));
        end
    end
    initial begin
        void'($urandom(32'h7C72));
        m = '{0, 64'h0, {4{16'hFFFF}}, {4{16'h8000}}, 64'h0, 1'b0, 18'h0};
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        note(1);
        $display("test reset done");
        // every select code twice, back to back, ending with a miss and a read
        repeat (2) for (int s = 0; s < 8; s++) send(3'(s), strap, 1'b0);
        send(3'h3, 2'h1, 1'b0);
        send(3'h2, strap, 1'b1);
        @(posedge mclk);
        go <= 1'b0;
        $display("test frames done");
        @(posedge mclk);
        cen <= 4'($urandom) | 4'h1;
        clr <= 1'b1;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 4; i++) if (cen[i]) m.d[16*i+:16] = m.c[16*i+:16];
        note(1);
        clr <= 1'b0;
        repeat (8) @(posedge mclk);
        $display("test clear done");
        if (q.size() > 0) n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        report_and_stop;
    end
endmodule : test_quad_dac_data_register_decode
`default_nettype wire
